// *** buck_startup_fault_sequencer.sv ***
// Start-up, overcurrent counting and hiccup sequencing of a buck controller.
// Assumes comparator and pin levels arrive asynchronously and are resampled.
// Function
// - Below the lockout level both gate drives are held off.
// - Oscillator and start-up run only with supply good and enable high.
// - Enable low forces shutdown with the internal 5 V rail turned off.
// - After the 5 V rail is up the comp node is sampled at 400 mV for 1 ms.
// - The sampled class picks a 280, 200 or 100 mV low-side trip level.
// - The comp node is then held low for 1 ms before any switching.
// - After both phases soft start engages and switching is allowed.
// - A cycle with either drop over its trip level counts the counter up.
// - A high-side drop over its fixed level ends that pulse at once.
// - A cycle with no drop over its trip level counts the counter down.
// - At a count of seven a fault turns both transistors off.
// - After a fault both stay off about 50 ms and then a restart is tried.
`timescale 1ns/1ps
`default_nettype none
module buck_startup_fault_sequencer #(
    parameter int SAMPLE_CYCLES = buck_seq_pkg::SAMPLE_CYCLES,
    parameter int PRECOND_CYCLES = buck_seq_pkg::PRECOND_CYCLES,
    parameter int HICCUP_CYCLES = buck_seq_pkg::HICCUP_CYCLES,
    parameter int SOFT_START_CYCLES = buck_seq_pkg::SOFT_START_CYCLES,
    parameter int SWITCH_DIV = buck_seq_pkg::SWITCH_DIV
) (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Supply and enable status from analog comparators.
    input wire logic supply_undervoltage_lockout_in,
    input wire logic enable_high_in,
    input wire logic rail_5v_good_in,
    // Resistor classification comparators during sampling.
    input wire logic comp_current_high_in,
    input wire logic comp_current_low_in,
    // Overcurrent comparators and PWM demand.
    input wire logic high_side_trip_in,
    input wire logic low_side_trip_in,
    input wire logic pwm_demand_in,
    // Gate drives and sequencing status.
    output logic high_side_gate_drive_out,
    output logic low_side_gate_drive_out,
    output logic internal_5v_rail_on_out,
    output logic oscillator_run_out,
    output logic comp_sample_drive_out,
    output logic comp_pull_low_out,
    output logic soft_start_out,
    output logic fault_out,
    output logic [8:0] low_side_trip_level_out
);
    logic supply_undervoltage_lockout_s, en_s, rail_s, cur_hi_s, cur_lo_s, hs_trip_s, ls_trip_s;
    logic [6:0] sync_v;

    pin_sync #(.WIDTH(7)) u_sync (
        .clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .async_in({supply_undervoltage_lockout_in, enable_high_in,
                   rail_5v_good_in, comp_current_high_in,
                   comp_current_low_in, high_side_trip_in,
                   low_side_trip_in}),
        .sync_out(sync_v)
    );
    assign {supply_undervoltage_lockout_s, en_s, rail_s, cur_hi_s, cur_lo_s, hs_trip_s, ls_trip_s}
        = sync_v;

    buck_seq_pkg::seq_state_t state_reg, state_next;
    logic [19:0] timer_reg, timer_next;
    logic [7:0] div_reg, div_next;
    logic [2:0] oc_reg, oc_next;
    logic cyc_trip_reg, cyc_trip_next;
    logic hs_cut_reg, hs_cut_next;
    logic [1:0] class_reg, class_next;
    logic high_side_gate_drive_reg, high_side_gate_drive_next, low_side_gate_drive_reg, low_side_gate_drive_next;
    logic rail_reg, rail_next, osc_reg, osc_next;
    logic samp_reg, samp_next, low_reg, low_next;
    logic ss_reg, ss_next, fault_reg, fault_next;
    logic [8:0] trip_reg, trip_next;
    logic power_ok, cycle_end, switching, trip_now;

    // Decodes a resistor class into the trip level in millivolts.
    function automatic logic [8:0] class_to_trip(input logic [1:0] cls);
        unique case (cls)
            buck_seq_pkg::CLASS_12K: class_to_trip = buck_seq_pkg::TRIP_280_MV;
            buck_seq_pkg::CLASS_4K: class_to_trip = buck_seq_pkg::TRIP_100_MV;
            default: class_to_trip = buck_seq_pkg::TRIP_200_MV;
        endcase
    endfunction : class_to_trip

    always_comb begin
        power_ok = !supply_undervoltage_lockout_s && en_s;
        switching = (state_reg == buck_seq_pkg::ST_SOFT) ||
                    (state_reg == buck_seq_pkg::ST_RUN);
        cycle_end = osc_reg && (div_reg == 8'(SWITCH_DIV - 1));
        trip_now = (high_side_gate_drive_reg && hs_trip_s) || (low_side_gate_drive_reg && ls_trip_s);
        state_next = state_reg;
        timer_next = timer_reg;
        div_next = cycle_end ? 8'h00 : (osc_reg ? div_reg + 8'h01 : 8'h00);
        oc_next = oc_reg;
        cyc_trip_next = cyc_trip_reg;
        hs_cut_next = hs_cut_reg;
        class_next = class_reg;
        trip_next = trip_reg;
        fault_next = fault_reg;
        unique case (state_reg)
            buck_seq_pkg::ST_OFF: begin
                timer_next = 20'h00000;
                if (power_ok && rail_s) begin
                    state_next = buck_seq_pkg::ST_SAMPLE;
                end
            end
            buck_seq_pkg::ST_SAMPLE: begin
                timer_next = timer_reg + 20'h00001;
                if (cur_hi_s) begin
                    class_next = buck_seq_pkg::CLASS_4K;
                end else if (cur_lo_s) begin
                    class_next = buck_seq_pkg::CLASS_12K;
                end else begin
                    class_next = buck_seq_pkg::CLASS_OPEN;
                end
                if (timer_reg == 20'(SAMPLE_CYCLES - 1)) begin
                    trip_next = class_to_trip(class_next);
                    timer_next = 20'h00000;
                    state_next = buck_seq_pkg::ST_PRECOND;
                end
            end
            buck_seq_pkg::ST_PRECOND: begin
                timer_next = timer_reg + 20'h00001;
                if (timer_reg == 20'(PRECOND_CYCLES - 1)) begin
                    timer_next = 20'h00000;
                    state_next = buck_seq_pkg::ST_SOFT;
                end
            end
            buck_seq_pkg::ST_SOFT: begin
                timer_next = timer_reg + 20'h00001;
                if (timer_reg == 20'(SOFT_START_CYCLES - 1)) begin
                    state_next = buck_seq_pkg::ST_RUN;
                end
            end
            buck_seq_pkg::ST_RUN: begin
                timer_next = 20'h00000;
            end
            buck_seq_pkg::ST_HICCUP: begin
                timer_next = timer_reg + 20'h00001;
                if (timer_reg == 20'(HICCUP_CYCLES - 1)) begin
                    timer_next = 20'h00000;
                    fault_next = 1'b0;
                    oc_next = buck_seq_pkg::OC_RESET;
                    state_next = buck_seq_pkg::ST_SOFT;
                end
            end
            default: state_next = buck_seq_pkg::ST_OFF;
        endcase
        if (switching) begin
            if (high_side_gate_drive_reg && hs_trip_s) begin
                hs_cut_next = 1'b1;
            end
            if (trip_now) begin
                cyc_trip_next = 1'b1;
            end
            if (cycle_end) begin
                cyc_trip_next = 1'b0;
                hs_cut_next = 1'b0;
                // A trip in the last clock still belongs to the ending cycle.
                if (cyc_trip_reg || trip_now) begin
                    oc_next = oc_reg + 3'h1;
                end else if (oc_reg != 3'h0) begin
                    oc_next = oc_reg - 3'h1;
                end
            end
            if (oc_reg == buck_seq_pkg::OC_FAULT_COUNT) begin
                fault_next = 1'b1;
                timer_next = 20'h00000;
                cyc_trip_next = 1'b0;
                state_next = buck_seq_pkg::ST_HICCUP;
            end
        end
        if (!power_ok) begin
            state_next = buck_seq_pkg::ST_OFF;
            oc_next = buck_seq_pkg::OC_RESET;
            fault_next = 1'b0;
            cyc_trip_next = 1'b0;
            hs_cut_next = 1'b0;
        end
        rail_next = en_s;
        osc_next = power_ok;
        samp_next = state_next == buck_seq_pkg::ST_SAMPLE;
        low_next = state_next == buck_seq_pkg::ST_PRECOND;
        ss_next = state_next == buck_seq_pkg::ST_SOFT;
        high_side_gate_drive_next = 1'b0;
        low_side_gate_drive_next = 1'b0;
        if ((state_next == buck_seq_pkg::ST_SOFT ||
             state_next == buck_seq_pkg::ST_RUN) && power_ok) begin
            high_side_gate_drive_next = pwm_demand_in && !hs_cut_next;
            low_side_gate_drive_next = !pwm_demand_in;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state_reg <= buck_seq_pkg::ST_OFF;
            timer_reg <= 20'h00000;
            div_reg <= 8'h00;
            oc_reg <= buck_seq_pkg::OC_RESET;
            cyc_trip_reg <= 1'b0;
            hs_cut_reg <= 1'b0;
            class_reg <= buck_seq_pkg::CLASS_OPEN;
            trip_reg <= buck_seq_pkg::TRIP_200_MV;
            high_side_gate_drive_reg <= 1'b0;
            low_side_gate_drive_reg <= 1'b0;
            rail_reg <= 1'b0;
            osc_reg <= 1'b0;
            samp_reg <= 1'b0;
            low_reg <= 1'b0;
            ss_reg <= 1'b0;
            fault_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            div_reg <= div_next;
            oc_reg <= oc_next;
            cyc_trip_reg <= cyc_trip_next;
            hs_cut_reg <= hs_cut_next;
            class_reg <= class_next;
            trip_reg <= trip_next;
            high_side_gate_drive_reg <= high_side_gate_drive_next;
            low_side_gate_drive_reg <= low_side_gate_drive_next;
            rail_reg <= rail_next;
            osc_reg <= osc_next;
            samp_reg <= samp_next;
            low_reg <= low_next;
            ss_reg <= ss_next;
            fault_reg <= fault_next;
        end
    end

    assign high_side_gate_drive_out = high_side_gate_drive_reg;
    assign low_side_gate_drive_out = low_side_gate_drive_reg;
    assign internal_5v_rail_on_out = rail_reg;
    assign oscillator_run_out = osc_reg;
    assign comp_sample_drive_out = samp_reg;
    assign comp_pull_low_out = low_reg;
    assign soft_start_out = ss_reg;
    assign fault_out = fault_reg;
    assign low_side_trip_level_out = trip_reg;
endmodule : buck_startup_fault_sequencer
`default_nettype wire

// *** buck_seq_pkg.sv ***
// Package of constants for the buck start-up and fault sequencer.
// Assumes a 10 MHz core clock; all timings are derived from it.
package buck_seq_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int SAMPLE_MS = 1;
    localparam int PRECOND_MS = 1;
    localparam int HICCUP_MS = 50;
    localparam int SAMPLE_CYCLES = SAMPLE_MS * (CLK_HZ / 1000);
    localparam int PRECOND_CYCLES = PRECOND_MS * (CLK_HZ / 1000);
    localparam int HICCUP_CYCLES = HICCUP_MS * (CLK_HZ / 1000);
    localparam int SOFT_START_MS = 4;
    localparam int SOFT_START_CYCLES = SOFT_START_MS * (CLK_HZ / 1000);
    localparam int SWITCH_HZ = 600000;
    localparam int SWITCH_DIV = CLK_HZ / SWITCH_HZ;
    localparam logic [2:0] OC_FAULT_COUNT = 3'h7;
    localparam logic [2:0] OC_RESET = 3'h0;
    // Trip level selections, value in millivolts.
    localparam logic [8:0] TRIP_280_MV = 9'h118;
    localparam logic [8:0] TRIP_200_MV = 9'h0C8;
    localparam logic [8:0] TRIP_100_MV = 9'h064;
    localparam logic [1:0] CLASS_OPEN = 2'h0;
    localparam logic [1:0] CLASS_12K = 2'h1;
    localparam logic [1:0] CLASS_4K = 2'h2;
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_SAMPLE = 6'h02,
        ST_PRECOND = 6'h04,
        ST_SOFT = 6'h08,
        ST_RUN = 6'h10,
        ST_HICCUP = 6'h20
    } seq_state_t;
endpackage : buck_seq_pkg

// *** pin_sync.sv ***
// Three-stage synchroniser for asynchronous pin inputs.
// Assumes one clock; the output changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [WIDTH-1:0] out_next;
    always_comb begin
        out_next = out_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                out_next[i] = s3_reg[i];
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            out_reg <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end
    assign sync_out = out_reg;
endmodule : pin_sync
`default_nettype wire

// *** buck_seq_monitor.sv ***
// Port checker for the buck start-up and fault sequencer.
// Assumes one clock domain and the bind at the foot of this file.
`timescale 1ns/1ps
`default_nettype none
module buck_seq_monitor #(
    parameter int SAMPLE_CYCLES = 1,
    parameter int PRECOND_CYCLES = 1,
    parameter int HICCUP_CYCLES = 1
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic supply_undervoltage_lockout_in,
    input wire logic enable_high_in,
    input wire logic high_side_gate_drive_out,
    input wire logic low_side_gate_drive_out,
    input wire logic internal_5v_rail_on_out,
    input wire logic oscillator_run_out,
    input wire logic comp_sample_drive_out,
    input wire logic comp_pull_low_out,
    input wire logic soft_start_out,
    input wire logic fault_out,
    input wire logic [8:0] low_side_trip_level_out
);
    // Phase lengths are counted here so that one slip shows as a count.
    int smp_reg = 0;
    int pre_reg = 0;
    int hic_reg = 0;
    logic off;
    assign off = !high_side_gate_drive_out && !low_side_gate_drive_out;
    always_ff @(posedge core_clk_in) begin
        smp_reg <= comp_sample_drive_out ? smp_reg + 1 : 0;
        pre_reg <= comp_pull_low_out ? pre_reg + 1 : 0;
        hic_reg <= fault_out ? hic_reg + 1 : 0;
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);
    // Six samples cover the pin synchroniser and the output register.
    sequence s_lock;
        supply_undervoltage_lockout_in [*6];
    endsequence
    sequence s_good;
        (enable_high_in && !supply_undervoltage_lockout_in) [*6];
    endsequence
    property p_lock_off;
        s_lock |-> off;
    endproperty
    a_lock_off: assert property (p_lock_off) else $error("drive in lockout");
    property p_osc;
        s_good |-> oscillator_run_out;
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator idle");
    property p_shut;
        !enable_high_in [*6] |-> !internal_5v_rail_on_out && off
            && !comp_sample_drive_out && !soft_start_out;
    endproperty
    a_shut: assert property (p_shut) else $error("not shut down");
    property p_smp;
        $fell(comp_sample_drive_out) && comp_pull_low_out
            |-> smp_reg == SAMPLE_CYCLES;
    endproperty
    a_smp: assert property (p_smp) else $error("sample length");
    property p_trip;
        $changed(low_side_trip_level_out)
            |-> comp_pull_low_out && $past(comp_sample_drive_out);
    endproperty
    a_trip: assert property (p_trip) else $error("trip level moved");
    property p_quiet;
        comp_sample_drive_out || comp_pull_low_out |-> off;
    endproperty
    a_quiet: assert property (p_quiet) else $error("early switching");
    property p_pre;
        $fell(comp_pull_low_out) && soft_start_out
            |-> pre_reg == PRECOND_CYCLES;
    endproperty
    a_pre: assert property (p_pre) else $error("precond length");
    property p_fault;
        fault_out |-> off;
    endproperty
    a_fault: assert property (p_fault) else $error("drive in fault");
    property p_hic;
        $fell(fault_out) && soft_start_out |-> hic_reg == HICCUP_CYCLES
            && !comp_sample_drive_out && $stable(low_side_trip_level_out);
    endproperty
    a_hic: assert property (p_hic) else $error("bad restart");
endmodule : buck_seq_monitor
bind buck_startup_fault_sequencer buck_seq_monitor #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .PRECOND_CYCLES(PRECOND_CYCLES),
    .HICCUP_CYCLES(HICCUP_CYCLES)
) buck_seq_monitor_inst (.core_clk_in, .reset_n_in,
    .supply_undervoltage_lockout_in, .enable_high_in,
    .high_side_gate_drive_out, .low_side_gate_drive_out,
    .internal_5v_rail_on_out, .oscillator_run_out, .comp_sample_drive_out,
    .comp_pull_low_out, .soft_start_out, .fault_out,
    .low_side_trip_level_out);
`default_nettype wire

// *** power_stage_model.sv ***
// Behavioural transistor pair and comp resistor beside the sequencer.
// Assumes the bench chooses the resistor class and when a short exists.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    // Clock and bench control.
    input wire logic clk_in,
    input wire logic short_in,
    input wire logic [1:0] cls_in,
    // Drives from the sequencer.
    input wire logic hs_in,
    input wire logic ls_in,
    input wire logic smp_in,
    // Comparator levels back.
    output logic hs_trip_out,
    output logic ls_trip_out,
    output logic cur_hi_out,
    output logic cur_lo_out
);
    logic junk_reg = 1'b0;
    always @(posedge clk_in) junk_reg <= !junk_reg;
    // Only a conducting transistor can show a drop.
    assign hs_trip_out = short_in && hs_in;
    assign ls_trip_out = short_in && ls_in;
    // An undriven comp node gives levels that mean nothing.
    assign cur_hi_out = smp_in ? cls_in == buck_seq_pkg::CLASS_4K : junk_reg;
    assign cur_lo_out = smp_in ? cls_in == buck_seq_pkg::CLASS_12K : !junk_reg;
endmodule : power_stage_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking bench for the buck start-up and fault sequencer.
// Assumes the bound monitor and the power stage model beside the design.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int DIV = 16;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic supply_undervoltage_lockout_in = 1'b1;
    logic enable_high_in = 1'b0;
    logic rail_5v_good_in = 1'b0;
    logic pwm_demand_in = 1'b0;
    logic short_on = 1'b0;
    logic [1:0] cls = 2'h0;
    logic comp_current_high_in, comp_current_low_in;
    logic high_side_trip_in, low_side_trip_in;
    logic high_side_gate_drive_out, low_side_gate_drive_out;
    logic internal_5v_rail_on_out, oscillator_run_out, fault_out;
    logic comp_sample_drive_out, comp_pull_low_out, soft_start_out;
    logic [8:0] low_side_trip_level_out;
    int bad_count = 0;
    int samples_checked = 0;
    int k;
    logic [31:0] seed = 32'h58D0;
    always #50 core_clk_in = !core_clk_in;
    // Short phase counts keep the run brief.
    buck_startup_fault_sequencer #(.SAMPLE_CYCLES(20), .PRECOND_CYCLES(20),
        .HICCUP_CYCLES(50), .SOFT_START_CYCLES(40), .SWITCH_DIV(DIV)
    ) buck_startup_fault_sequencer_inst (.core_clk_in, .reset_n_in,
        .supply_undervoltage_lockout_in, .enable_high_in, .rail_5v_good_in,
        .comp_current_high_in, .comp_current_low_in, .high_side_trip_in,
        .low_side_trip_in, .pwm_demand_in, .high_side_gate_drive_out,
        .low_side_gate_drive_out, .internal_5v_rail_on_out,
        .oscillator_run_out, .comp_sample_drive_out, .comp_pull_low_out,
        .soft_start_out, .fault_out, .low_side_trip_level_out);
    power_stage_model power_stage_model_inst (.clk_in(core_clk_in),
        .short_in(short_on), .cls_in(cls), .hs_in(high_side_gate_drive_out),
        .ls_in(low_side_gate_drive_out), .smp_in(comp_sample_drive_out),
        .hs_trip_out(high_side_trip_in), .ls_trip_out(low_side_trip_in),
        .cur_hi_out(comp_current_high_in), .cur_lo_out(comp_current_low_in));
    function logic xs_bit();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[0];
    endfunction : xs_bit
    function logic [8:0] mv_of(input logic [1:0] c);
        if (c == buck_seq_pkg::CLASS_12K) return buck_seq_pkg::TRIP_280_MV;
        if (c == buck_seq_pkg::CLASS_4K) return buck_seq_pkg::TRIP_100_MV;
        return buck_seq_pkg::TRIP_200_MV;
    endfunction : mv_of
    function logic pick(input int w);
        if (w == 0) return comp_pull_low_out;
        if (w == 1) return soft_start_out;
        if (w == 2) return fault_out;
        return !fault_out;
    endfunction : pick
    task tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask : tick
    task check(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask : check
    task check_bit(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t flag got %b want %b", $time, got, exp);
        end
    endtask : check_bit
    task final_report();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task wait_hi(input int w, input int lim);
        int i;
        for (i = 0; i < lim && pick(w) !== 1'b1; i++) tick(1);
        if (pick(w) !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t wait ran out", $time);
            final_report();
        end
    endtask : wait_hi
    task follow(input int n, input bit chk);
        logic d;
        repeat (n) begin
            d = xs_bit();
            pwm_demand_in = d;
            tick(1);
            if (chk) check_bit(high_side_gate_drive_out, d);
            if (chk) check_bit(low_side_gate_drive_out, !d);
        end
    endtask : follow
    task power_up(input logic [1:0] c);
        cls = c;
        supply_undervoltage_lockout_in = 1'b0;
        rail_5v_good_in = 1'b1;
        enable_high_in = 1'b1;
        wait_hi(0, 200);
        check(low_side_trip_level_out, mv_of(c));
        wait_hi(1, 200);
        check_bit(oscillator_run_out, 1'b1);
    endtask : power_up
    task count_hs();
        k = 0;
        repeat (DIV) begin
            tick(1);
            k += (high_side_gate_drive_out === 1'b1);
        end
    endtask : count_hs
    initial begin
        tick(4);
        reset_n_in = 1'b1;
        check(low_side_trip_level_out, buck_seq_pkg::TRIP_200_MV);
        enable_high_in = 1'b1;
        tick(10);
        check_bit(oscillator_run_out, 1'b0);
        check_bit(comp_sample_drive_out, 1'b0);
        for (int c = 0; c < 3; c++) begin
            power_up(c[1:0]);
            follow(24, 1'b1);
            enable_high_in = 1'b0;
            tick(8);
            check_bit(internal_5v_rail_on_out, 1'b0);
            $display("test class %0d done", c);
        end
        power_up(buck_seq_pkg::CLASS_OPEN);
        pwm_demand_in = 1'b1;
        tick(DIV);
        count_hs();
        check(9'(k), 9'(DIV));
        short_on = 1'b1;
        tick(8);
        count_hs();
        check_bit(k < DIV, 1'b1);
        wait_hi(2, 400);
        short_on = 1'b0;
        check_bit(high_side_gate_drive_out, 1'b0);
        check_bit(low_side_gate_drive_out, 1'b0);
        wait_hi(3, 80);
        check_bit(soft_start_out, 1'b1);
        check_bit(comp_sample_drive_out, 1'b0);
        check(low_side_trip_level_out, buck_seq_pkg::TRIP_200_MV);
        tick(2);
        check_bit(fault_out, 1'b0);
        $display("test hiccup done");
        short_on = 1'b1;
        follow(3 * DIV, 1'b0);
        short_on = 1'b0;
        follow(10 * DIV, 1'b0);
        short_on = 1'b1;
        follow(5 * DIV, 1'b0);
        short_on = 1'b0;
        check_bit(fault_out, 1'b0);
        supply_undervoltage_lockout_in = 1'b1;
        tick(8);
        check_bit(high_side_gate_drive_out, 1'b0);
        check_bit(low_side_gate_drive_out, 1'b0);
        check_bit(oscillator_run_out, 1'b0);
        $display("test counter and lockout done");
        final_report();
    end
endmodule : tb_top
`default_nettype wire
